//--- rtl/sac_adc_ctrl.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sac_adc_ctrl
  import sac_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       cpu_wait,
  input  wire logic       cpu_halt,
  input  wire logic       cmp_above_ref,
  input  wire logic       cmp_below_ref,
  input  wire logic       cmp_high,
  output logic      [3:0] analog_input_sel,
  output logic      [9:0] dac_probe,
  output logic            analog_enable,
  output logic            sample_hold,
  output logic            irq
);
  sac_state_t       state;
  sac_state_t       next_state;
  logic [7:0]       ctrl;
  logic             done_flag;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] probe;
  logic [3:0]       bit_idx;
  logic [1:0]       div_cnt;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [1:0]       above_sync;
  logic [1:0]       below_sync;
  logic [1:0]       cmp_sync;
  logic [1:0]       halt_sync;

  // comparator and halt pins pass two flops before anything reads them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      above_sync <= 2'h0;
      below_sync <= 2'h0;
      cmp_sync   <= 2'h0;
      halt_sync  <= 2'h0;
    end else begin
      above_sync <= {above_sync[0], cmp_above_ref};
      below_sync <= {below_sync[0], cmp_below_ref};
      cmp_sync   <= {cmp_sync[0], cmp_high};
      halt_sync  <= {halt_sync[0], cpu_halt};
    end
  end

  wire       in_above = above_sync[1];
  wire       in_below = below_sync[1];
  wire       in_cmp   = cmp_sync[1];
  wire       halted   = halt_sync[1];

  // bus decode
  wire       wr_ctrl  = wr && (addr == ADDR_CTRL_STATUS);
  wire       wr_istat = wr && (addr == ADDR_IRQ_STATUS);
  wire       wr_imask = wr && (addr == ADDR_IRQ_MASK);
  wire       rd_high  = rd && (addr == ADDR_RESULT_HIGH);
  wire [3:0] new_ch   = wdata[CH_MSB:CH_LSB];
  wire       ch_chg   = wr_ctrl && (new_ch != ctrl[CH_MSB:CH_LSB]);
  // wait is deliberately ignored so conversions keep going
  wire       conv_on  = ctrl[BIT_ON] && !halted;
  wire       busy     = (state != SAC_IDLE);
  wire [1:0] div_last = ctrl[BIT_SPEED] ? DIV_FAST_LAST : DIV_SLOW_LAST;
  wire       tick     = (div_cnt == div_last);
  wire       last_bit = (state == SAC_CONV) && tick && (bit_idx == BIT_LAST);
  logic [RES_W-1:0] step_trial;
  logic [RES_W-1:0] step_probe;
  logic [RES_W-1:0] final_code;

  sac_sar_step u_step (
    .trial      (trial),
    .bit_idx    (bit_idx),
    .cmp_high   (in_cmp),
    .next_trial (step_trial),
    .next_probe (step_probe)
  );

  // out-of-range inputs override the search result
  assign final_code = in_above ? RES_FULL : (in_below ? RES_ZERO : step_trial);

  // control register; done bit and reserved bit stay hardware-owned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= wdata & CTRL_WMASK;
    end
  end

  // converter clock prescaler, restarted with each conversion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 2'h0;
    end else if (!busy || tick || wr_ctrl) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // sequencer: any control write throws the current search away
  always_comb begin
    next_state = state;
    case (state)
      SAC_IDLE:   next_state = conv_on ? SAC_SAMPLE : SAC_IDLE;
      SAC_SAMPLE: next_state = tick ? SAC_CONV : SAC_SAMPLE;
      SAC_CONV:   next_state = last_bit ? SAC_SAMPLE : SAC_CONV;
      default:    next_state = SAC_IDLE;
    endcase
    if (!conv_on || wr_ctrl) begin
      next_state = SAC_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // successive approximation register and bit pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trial   <= RES_ZERO;
      probe   <= RES_ZERO;
      bit_idx <= 4'h0;
    end else if (state == SAC_SAMPLE && tick) begin
      trial   <= RES_FULL;
      probe   <= RES_W'(10'h200);
      bit_idx <= 4'h0;
    end else if (state == SAC_CONV && tick) begin
      trial   <= step_trial;
      probe   <= step_probe;
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // results are overwritten each conversion, never held for software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= RES_ZERO;
    end else if (last_bit && !wr_ctrl) begin
      result <= final_code;
    end
  end

  // done flag: completion wins over a result_high read, control writes win over all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_flag <= 1'b0;
    end else if (wr_ctrl) begin
      done_flag <= 1'b0;
    end else if (last_bit) begin
      done_flag <= 1'b1;
    end else if (rd_high) begin
      done_flag <= 1'b0;
    end
  end

  // local events only: an aborted search and an unread result overwritten
  wire [IRQ_W-1:0] events = {last_bit && done_flag && !rd_high && !wr_ctrl,
                             wr_ctrl && busy};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= (irq_status & ~(wr_istat ? wdata[IRQ_W-1:0] : '0)) | events;
      if (wr_imask) begin
        irq_mask <= wdata[IRQ_W-1:0];
      end
    end
  end
  // end of conversion itself is never an interrupt source
  assign irq = |(irq_status & irq_mask);

  // read data, valid in the cycle after the strobe
  logic [7:0] next_rdata;
  always_comb begin
    case (addr)
      ADDR_CTRL_STATUS: next_rdata = {done_flag, ctrl[6:0]};
      ADDR_RESULT_HIGH: next_rdata = result[9:2];
      ADDR_RESULT_LOW:  next_rdata = {6'h00, result[1:0]};
      ADDR_IRQ_STATUS:  next_rdata = {6'h00, irq_status};
      ADDR_IRQ_MASK:    next_rdata = {6'h00, irq_mask};
      default:          next_rdata = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= BYTE_ZERO;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= BYTE_ZERO;
    end
  end

  // analog side
  assign analog_input_sel = ctrl[CH_MSB:CH_LSB];
  assign analog_enable    = conv_on;
  assign sample_hold      = (state == SAC_SAMPLE);
  assign dac_probe        = probe;

  // completion raises the flag one edge later
  AST_DONE_SET: assert property (@(posedge clk) disable iff (rst)
    (last_bit && !wr_ctrl) |=> done_flag)
    else $error("done flag not set after conversion");

  AST_RDH_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (rd_high && !last_bit && !wr_ctrl) |=> !done_flag)
    else $error("result_high read did not clear done");

  AST_WR_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> (!done_flag && state == SAC_IDLE))
    else $error("control write did not clear done and restart");

  AST_CH_RESTART: assert property (@(posedge clk) disable iff (rst)
    (ch_chg && wdata[BIT_ON] && !halted) |=> ##1 (state == SAC_SAMPLE))
    else $error("channel change did not restart conversion");

  AST_OFF_IDLE: assert property (@(posedge clk) disable iff (rst)
    (!ctrl[BIT_ON]) |-> (state == SAC_IDLE && !analog_enable))
    else $error("converter active while off");

  AST_FULL_SCALE: assert property (@(posedge clk) disable iff (rst)
    (last_bit && !wr_ctrl && in_above) |=> (result == RES_FULL))
    else $error("full scale not reported");

  AST_ZERO_SCALE: assert property (@(posedge clk) disable iff (rst)
    (last_bit && !wr_ctrl && in_below && !in_above) |=> (result == RES_ZERO))
    else $error("zero scale not reported");

  AST_LOW_READ: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == ADDR_RESULT_LOW) |=> (rdata[7:2] == 6'h00 && rdata[1:0] == $past(result[1:0])))
    else $error("result_low read wrong");

  AST_DIV_SLOW: assert property (@(posedge clk) disable iff (rst)
    (busy && !ctrl[BIT_SPEED] && div_cnt == 2'h0 && !wr_ctrl) |=> (div_cnt == 2'h1) ##1 (!tick))
    else $error("slow divider wrong");

  AST_CONTINUOUS: assert property (@(posedge clk) disable iff (rst)
    (last_bit && !wr_ctrl && conv_on) |=> (state == SAC_SAMPLE))
    else $error("conversion not continuous");

  AST_WAIT_RUN: assert property (@(posedge clk) disable iff (rst)
    (cpu_wait && conv_on && !wr_ctrl && state == SAC_IDLE) |=> (state == SAC_SAMPLE))
    else $error("wait mode stopped converter");
endmodule
`default_nettype wire

//--- rtl/sac_sar_step.sv
`timescale 1ns/100ps
`default_nettype none
// one successive-approximation trial: keep or drop the bit under test
module sac_sar_step
  import sac_pkg::*;
(
  input  wire logic [RES_W-1:0] trial,
  input  wire logic [3:0]       bit_idx,
  input  wire logic             cmp_high,
  output logic      [RES_W-1:0] next_trial,
  output logic      [RES_W-1:0] next_probe
);
  logic [RES_W-1:0] bit_mask;
  logic [RES_W-1:0] kept;
  logic [RES_W-1:0] low_ones;

  // bit_idx counts from 0 (msb) to 9 (lsb)
  assign bit_mask   = RES_W'(10'h200 >> bit_idx);
  // bits below the one under test are still undecided ones in trial
  assign low_ones   = RES_W'(10'h1FF >> bit_idx);
  // comparator high means analog input below probe: drop the bit
  assign kept       = cmp_high ? (trial & ~bit_mask) : trial;
  assign next_trial = kept;
  // probe only the decided upper bits plus the next bit, else the dac overshoots
  assign next_probe = (kept & ~low_ones) | (bit_mask >> 1);
endmodule
`default_nettype wire

//--- shared/sac_pkg.sv
package sac_pkg;
  // register map, byte registers on the plain port
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h70;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h71;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h72;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h73;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h74;

  // control/status field positions
  localparam int BIT_DONE  = 7;
  localparam int BIT_SPEED = 6;
  localparam int BIT_ON    = 5;
  localparam int CH_MSB    = 3;
  localparam int CH_LSB    = 0;

  // writable bits of the control register (done flag and bit 4 excluded)
  localparam logic [7:0] CTRL_WMASK  = 8'h6F;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // result width and full/zero scale codes
  localparam int          RES_W        = 10;
  localparam logic [9:0]  RES_FULL     = 10'h3FF;
  localparam logic [9:0]  RES_ZERO     = 10'h000;
  localparam logic [7:0]  HIGH_FULL    = 8'hFF;
  localparam logic [1:0]  LOW_FULL     = 2'h3;

  // converter clock divider: divide by 4 when speed clear, by 2 when set
  localparam logic [1:0]  DIV_SLOW_LAST = 2'h3;
  localparam logic [1:0]  DIV_FAST_LAST = 2'h1;

  // sample phase plus one converter tick per result bit
  localparam logic [3:0]  SAMPLE_TICKS = 4'h1;
  localparam logic [3:0]  BIT_LAST     = 4'h9;

  // interrupt event bits (local events only, end of conversion excluded)
  localparam int IRQ_W       = 2;
  localparam int EV_ABORT    = 0;
  localparam int EV_OVERRUN  = 1;

  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_CONV   = 2'b10
  } sac_state_t;
endpackage

//--- verif/sac_adc_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sac_adc_ctrl_bench
  import sac_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       chk = 1'b0;
  logic       chk_q = 1'b0;
  logic       cpu_wait = 1'b0;
  logic       cpu_halt = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [3:0] sel;
  logic [9:0] probe;
  logic       en;
  logic       irq;
  logic       ab;
  logic       be;
  logic       hi;
  logic [9:0] code [16];
  logic [7:0] expq [$];
  int         fails = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         seed = 32'hB75BEE76;

  sac_adc_ctrl sac_adc_ctrl_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt), .cmp_above_ref(ab),
    .cmp_below_ref(be), .cmp_high(hi), .analog_input_sel(sel), .dac_probe(probe),
    .analog_enable(en), .sample_hold(), .irq(irq));
  sac_analog_model sac_analog_model_i (.clk(clk), .analog_input_sel(sel), .dac_probe(probe),
    .analog_enable(en), .cmp_above_ref(ab), .cmp_below_ref(be), .cmp_high(hi));

  task check(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one-cycle write strobe; settle past the edge before returning
  task wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // one-cycle read; c queues an expectation for the monitor
  task rreg(input logic [7:0] a, input logic [7:0] e, input logic c);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    chk <= c;
    if (c) expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    chk <= 1'b0;
    #1 d = rdata;
  endtask

  // bounded poll of the done flag
  task wait_done;
    int n;
    n = 0;
    d = 8'h00;
    while (d[BIT_DONE] !== 1'b1 && n < 200) begin
      rreg(ADDR_CTRL_STATUS, 8'h00, 1'b0);
      n++;
    end
    check(d[BIT_DONE], 1'b1);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (chk_q) check(rdata, expq.pop_front());
    chk_q <= chk;
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      end_sim();
    end
  end

  initial forever #50 clk = ~clk;

  initial begin
    for (int c = 0; c < 16; c++) begin
      code[c] = 10'($random(seed));
      sac_analog_model_i.level[c] = code[c];
    end
    sac_analog_model_i.above = 16'h0020;
    sac_analog_model_i.below = 16'h0200;
    code[5] = RES_FULL;
    code[9] = RES_ZERO;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values, then an unmapped address
    for (int i = 0; i < 6; i++) rreg((i == 5) ? 8'h80 : 8'(8'h70 + i), BYTE_ZERO, 1'b1);
    $display("test reset done");
    wreg(ADDR_IRQ_MASK, 8'h02);
    // every channel; bits 7 and 4 written high must not stick
    for (int c = 0; c < 16; c++) begin
      cpu_wait <= 1'($random(seed));
      wreg(ADDR_CTRL_STATUS, 8'h90 | 8'h20 | 8'(c));
      check(sel, 10'(c));
      check(en, 1'b1);
      rreg(ADDR_CTRL_STATUS, 8'h20 | 8'(c), 1'b1);
      wait_done();
      rreg(ADDR_RESULT_LOW, {6'h00, code[c][1:0]}, 1'b1);
      rreg(ADDR_RESULT_HIGH, code[c][9:2], 1'b1);
      rreg(ADDR_CTRL_STATUS, 8'h20 | 8'(c), 1'b1);
      wait_done();
      rreg(ADDR_RESULT_HIGH, code[c][9:2], 1'b1);
      check(irq, 1'b0);
    end
    $display("test channels done");
    // restart while busy raises the abort event
    wreg(ADDR_IRQ_STATUS, 8'h03);
    wreg(ADDR_IRQ_MASK, 8'h01);
    check(irq, 1'b0);
    wreg(ADDR_CTRL_STATUS, 8'h23);
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    rreg(ADDR_IRQ_STATUS, 8'h01, 1'b1);
    wreg(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    // channel change while done is still set
    wait_done();
    repeat (20) @(posedge clk);
    wreg(ADDR_CTRL_STATUS, 8'h25);
    rreg(ADDR_CTRL_STATUS, 8'h25, 1'b1);
    wait_done();
    rreg(ADDR_RESULT_LOW, {6'h00, LOW_FULL}, 1'b1);
    rreg(ADDR_RESULT_HIGH, HIGH_FULL, 1'b1);
    // unread results get overwritten
    wreg(ADDR_IRQ_STATUS, 8'h03);
    wreg(ADDR_IRQ_MASK, 8'h02);
    repeat (120) @(posedge clk);
    check(irq, 1'b1);
    wreg(ADDR_IRQ_MASK, 8'h00);
    check(irq, 1'b0);
    $display("test events done");
    // converter off: no completion
    wreg(ADDR_CTRL_STATUS, 8'h05);
    check(en, 1'b0);
    repeat (120) @(posedge clk);
    rreg(ADDR_CTRL_STATUS, 8'h05, 1'b1);
    // halt stops it; allow settle time after wakeup
    wreg(ADDR_CTRL_STATUS, 8'h29);
    cpu_halt <= 1'b1;
    repeat (4) @(posedge clk);
    check(en, 1'b0);
    repeat (120) @(posedge clk);
    rreg(ADDR_CTRL_STATUS, 8'h29, 1'b1);
    cpu_halt <= 1'b0;
    repeat (20) @(posedge clk);
    wait_done();
    rreg(ADDR_RESULT_HIGH, RES_ZERO[9:2], 1'b1);
    $display("test power done");
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire

//--- verif/sac_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
// mux and comparator stand-in; the bench loads the levels
module sac_analog_model (
  input  wire logic       clk,
  input  wire logic [3:0] analog_input_sel,
  input  wire logic [9:0] dac_probe,
  input  wire logic       analog_enable,
  output logic            cmp_above_ref,
  output logic            cmp_below_ref,
  output logic            cmp_high
);
  logic [9:0]  level [16];
  logic [15:0] above = 16'h0000;
  logic [15:0] below = 16'h0000;
  logic        junk  = 1'b0;

  // unpowered comparator gives no stable answer, so toggle it
  always @(posedge clk) junk <= ~junk;

  // range flags and compare follow the selected input
  assign cmp_above_ref = above[analog_input_sel];
  assign cmp_below_ref = below[analog_input_sel];
  assign cmp_high = !analog_enable ? junk : (level[analog_input_sel] < dac_probe);
endmodule
`default_nettype wire
